// ---- verilog/fpes_top.sv ----
// Our own choices: the register offsets and the plain strobed port.
`default_nettype none
module fpes_top
	import fpes_pkg::*;
#(
	parameter int CODE_BYTES = 16384,
	parameter int DATA_BYTES = 4096,
	parameter int CODE_AW    = 14,
	parameter int DATA_AW    = 12,
	parameter logic [31:0] STORED_ID = 32'h1234_5678  // arbitrary value
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        fetch_req,
	input  wire logic [CODE_AW-1:0] fetch_addr,
	output logic      [7:0]  fetch_data,
	output logic             fetch_valid,
	input  wire logic        boot_mode,
	output logic             serial_prog_enable,
	output logic             debug_enable,
	output logic             flash_ready_irq
);
	localparam int CBLK_AW = $clog2(FPES_CODE_BLOCK_BYTES);
	localparam int DBLK_AW = $clog2(FPES_DATA_BLOCK_BYTES);
	localparam int CACHE_AW = $clog2(FPES_CACHE_BYTES);
	localparam int CNT_W = 12;

	logic [7:0] code_mem [CODE_BYTES];
	logic [7:0] data_mem [DATA_BYTES];
	logic [7:0] cache_mem [FPES_CACHE_BYTES];
	logic [CODE_AW-CACHE_AW-1:0] cache_tag [FPES_CACHE_BYTES];
	logic cache_vld [FPES_CACHE_BYTES];

	logic [7:0]  status_low_q;
	logic        seq_ready_q;
	logic        extra_ready_q;
	logic [7:0]  entry_q;
	logic [31:0] addr_q;
	logic [31:0] wlo_q;
	logic [31:0] whi_q;
	logic [15:0] protect_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic [7:0]  clk_mhz_q;
	logic [31:0] id_q;
	logic [7:0]  rd_byte_q;
	fpes_state_t state_q;
	logic        area_data_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] last_q;
	logic        fail_q;
	logic        done_pulse;
	logic        bad_pulse;

	logic [3:0]  cmd_code;
	logic        cmd_wr;
	logic        cmd_data_area;
	logic        entry_ok;
	logic        range_ok;
	logic        cmd_ok;
	logic [7:0]  code_block;

	assign cmd_wr = reg_wr && reg_addr == FPES_ADDR_COMMAND;
	assign cmd_code = reg_wdata[3:0];
	assign cmd_data_area = reg_wdata[FPES_BIT_AREA_DATA];
	assign code_block = 8'(addr_q >> CBLK_AW);
	assign entry_ok = cmd_data_area ? entry_q[FPES_BIT_ENTRY_DATA]
		: entry_q[FPES_BIT_ENTRY_CODE];
	// protect_q: [7:0] first block, [15:8] last block allowed to rewrite
	assign range_ok = cmd_data_area || cmd_code == FPES_CMD_BLANK
		|| (code_block >= protect_q[7:0] && code_block <= protect_q[15:8]);
	// unknown codes are refused so the ready flag can never be stranded
	assign cmd_ok = seq_ready_q && entry_ok && range_ok && (cmd_code == FPES_CMD_PROGRAM
		|| cmd_code == FPES_CMD_BLANK || cmd_code == FPES_CMD_ERASE);

	// command sequencer
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q     <= FPES_IDLE;
			area_data_q <= 1'b0;
			cnt_q       <= '0;
			last_q      <= '0;
		end else begin
			case (state_q)
				FPES_IDLE: begin
					cnt_q <= '0;
					if (cmd_wr && cmd_code == FPES_CMD_EXTRA && seq_ready_q) begin
						state_q <= FPES_EXTRA;
					end else if (cmd_wr && cmd_ok) begin
						area_data_q <= cmd_data_area;
						case (cmd_code)
							FPES_CMD_PROGRAM: begin
								state_q <= FPES_PROG;
								last_q <= cmd_data_area ? CNT_W'(FPES_DATA_PROG_BYTES - 1)
									: CNT_W'(FPES_CODE_PROG_BYTES - 1);
							end
							FPES_CMD_ERASE: begin
								state_q <= FPES_ERASE;
								last_q <= cmd_data_area ? CNT_W'(FPES_DATA_BLOCK_BYTES - 1)
									: CNT_W'(FPES_CODE_BLOCK_BYTES - 1);
							end
							FPES_CMD_BLANK: begin
								state_q <= FPES_BLANK;
								last_q <= cmd_data_area ? CNT_W'(FPES_DATA_BLOCK_BYTES - 1)
									: CNT_W'(FPES_CODE_BLOCK_BYTES - 1);
							end
							default: state_q <= FPES_IDLE;
						endcase
					end
				end
				FPES_ERASE, FPES_PROG, FPES_BLANK: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == last_q) begin
						state_q <= FPES_DONE;
					end
				end
				FPES_EXTRA: state_q <= FPES_DONE;
				default: state_q <= FPES_IDLE;
			endcase
		end
	end

	// block-aligned or unit-aligned target addresses
	logic [31:0] cbase;
	logic [31:0] dbase;
	logic [31:0] cptr;
	logic [31:0] dptr;
	assign cbase = (state_q == FPES_PROG) ? {addr_q[31:3], 3'b000}
		: {addr_q[31:CBLK_AW], {CBLK_AW{1'b0}}};
	assign dbase = (state_q == FPES_PROG) ? addr_q
		: {addr_q[31:DBLK_AW], {DBLK_AW{1'b0}}};
	assign cptr = cbase + 32'(cnt_q);
	assign dptr = dbase + 32'(cnt_q);

	logic [7:0] prog_byte;
	assign prog_byte = cnt_q[2] ? 8'(whi_q >> {cnt_q[1:0], 3'b000})
		: 8'(wlo_q >> {cnt_q[1:0], 3'b000});

	// array writes; flash programming can only clear bits
	always_ff @(posedge clock) begin
		if (state_q == FPES_ERASE || state_q == FPES_PROG) begin
			if (area_data_q) begin
				if (dptr < 32'(DATA_BYTES)) begin
					data_mem[dptr[DATA_AW-1:0]] <= (state_q == FPES_ERASE) ? FPES_ERASED
						: data_mem[dptr[DATA_AW-1:0]] & prog_byte;
				end
			end else if (cptr < 32'(CODE_BYTES)) begin
				code_mem[cptr[CODE_AW-1:0]] <= (state_q == FPES_ERASE) ? FPES_ERASED
					: code_mem[cptr[CODE_AW-1:0]] & prog_byte;
			end
		end
	end

	logic [7:0] cur_byte;
	assign cur_byte = area_data_q ? data_mem[dptr[DATA_AW-1:0]] : code_mem[cptr[CODE_AW-1:0]];

	// failure tracking: blank check fails on any programmed bit
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fail_q <= 1'b0;
		end else if (state_q == FPES_IDLE) begin
			fail_q <= 1'b0;
		end else if (state_q == FPES_BLANK && cur_byte != FPES_ERASED) begin
			fail_q <= 1'b1;
		end else if (state_q == FPES_PROG && (cur_byte & prog_byte) != prog_byte) begin
			fail_q <= 1'b1;
		end
	end

	assign done_pulse = state_q == FPES_DONE;
	assign bad_pulse = cmd_wr && seq_ready_q && !(cmd_code == FPES_CMD_EXTRA) && !cmd_ok;

	logic [1:0] last_op_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			last_op_q <= 2'h0;
		end else if (state_q == FPES_ERASE) begin
			last_op_q <= 2'h1;
		end else if (state_q == FPES_PROG) begin
			last_op_q <= 2'h2;
		end else if (state_q == FPES_BLANK) begin
			last_op_q <= 2'h3;
		end
	end

	// status flags; a new command clears the error flags
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			status_low_q  <= '0;
			seq_ready_q   <= 1'b1;
			extra_ready_q <= 1'b1;
		end else begin
			if (state_q == FPES_IDLE && cmd_wr && seq_ready_q) begin
				status_low_q <= '0;
				if (!entry_ok || !range_ok) begin
					if (cmd_code == FPES_CMD_ERASE) begin
						status_low_q[FPES_BIT_ERASE_ERR] <= 1'b1;
					end
					if (cmd_code == FPES_CMD_PROGRAM) begin
						status_low_q[FPES_BIT_PROG_ERR] <= 1'b1;
					end
				end
				if (cmd_code == FPES_CMD_EXTRA && !entry_q[FPES_BIT_ENTRY_CODE]) begin
					status_low_q[FPES_BIT_EXTRA_BAD] <= 1'b1;
				end
			end
			if (done_pulse && fail_q) begin
				case (last_op_q)
					2'h1: status_low_q[FPES_BIT_ERASE_ERR] <= 1'b1;
					2'h2: status_low_q[FPES_BIT_PROG_ERR] <= 1'b1;
					2'h3: status_low_q[FPES_BIT_BLANK_ERR] <= 1'b1;
					default: ;
				endcase
			end
			if (state_q == FPES_IDLE && cmd_wr && cmd_ok) begin
				seq_ready_q <= 1'b0;
			end else if (state_q == FPES_IDLE && cmd_wr && seq_ready_q
				&& cmd_code == FPES_CMD_EXTRA) begin
				seq_ready_q   <= 1'b0;
				extra_ready_q <= 1'b0;
			end else if (done_pulse) begin
				seq_ready_q   <= 1'b1;
				extra_ready_q <= 1'b1;
			end
		end
	end

	// code fetch path with direct-mapped cache; requests are ignored while the sequencer erases or programs code flash
	logic [CACHE_AW-1:0] cidx;
	logic [CODE_AW-CACHE_AW-1:0] ctag;
	logic hit;
	logic slow;
	logic wait_q;
	logic [CODE_AW-1:0] pend_addr_q;
	assign cidx = fetch_addr[CACHE_AW-1:0];
	assign ctag = fetch_addr[CODE_AW-1:CACHE_AW];
	assign hit = cache_vld[cidx] && cache_tag[cidx] == ctag;
	assign slow = clk_mhz_q > 8'(FPES_WAIT_LIMIT_MHZ);
	logic code_busy;
	// a code rewrite invalidates cached bytes; data operations leave fetches alone
	assign code_busy = !area_data_q && (state_q == FPES_ERASE || state_q == FPES_PROG);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fetch_valid <= 1'b0;
			fetch_data  <= '0;
			wait_q      <= 1'b0;
			pend_addr_q <= '0;
			for (int i = 0; i < FPES_CACHE_BYTES; i++) begin
				cache_vld[i] <= 1'b0;
			end
		end else begin
			fetch_valid <= 1'b0;
			if (code_busy) begin
				cache_vld[cptr[CACHE_AW-1:0]] <= 1'b0;
			end
			if (wait_q) begin
				wait_q      <= 1'b0;
				fetch_valid <= 1'b1;
				fetch_data  <= code_mem[pend_addr_q];
			end else if (fetch_req && !code_busy) begin
				if (hit) begin
					fetch_valid <= 1'b1;
					fetch_data  <= cache_mem[cidx];
				end else if (slow) begin
					wait_q      <= 1'b1;
					pend_addr_q <= fetch_addr;
				end else begin
					fetch_valid <= 1'b1;
					fetch_data  <= code_mem[fetch_addr];
				end
				cache_vld[cidx] <= 1'b1;
				cache_tag[cidx] <= ctag;
				cache_mem[cidx] <= code_mem[fetch_addr];
			end
		end
	end

	// software registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			entry_q   <= '0;
			addr_q    <= FPES_RST_ZERO;
			wlo_q     <= FPES_RST_ZERO;
			whi_q     <= FPES_RST_ZERO;
			protect_q <= '0;
			irq_mask_q <= '0;
			clk_mhz_q <= FPES_RST_CLOCK_MHZ;
			id_q      <= FPES_RST_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				FPES_ADDR_ENTRY: entry_q <= reg_wdata[7:0] & 8'h81;
				FPES_ADDR_ADDRESS: addr_q <= reg_wdata;
				FPES_ADDR_WDATA_LO: wlo_q <= reg_wdata;
				FPES_ADDR_WDATA_HI: whi_q <= reg_wdata;
				FPES_ADDR_PROTECT: protect_q <= reg_wdata[15:0];
				FPES_ADDR_IRQ_MASK: irq_mask_q <= reg_wdata[1:0];
				FPES_ADDR_CLOCK_CFG: clk_mhz_q <= reg_wdata[7:0];
				FPES_ADDR_ID_CODE: id_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// boot mode is a pin, not timed to the core clock: two flops first
	logic boot_meta_q;
	logic boot_sync_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			boot_meta_q <= 1'b0;
			boot_sync_q <= 1'b0;
		end else begin
			boot_meta_q <= boot_mode;
			boot_sync_q <= boot_meta_q;
		end
	end

	// id code gating: serial programmer in boot mode, debugger always
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			serial_prog_enable <= 1'b0;
			debug_enable       <= 1'b0;
		end else begin
			serial_prog_enable <= boot_sync_q && id_q == STORED_ID;
			debug_enable       <= id_q == STORED_ID;
		end
	end

	// interrupt: bit0 done, bit1 refused command; set wins over clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irq_stat_q      <= '0;
			flash_ready_irq <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == FPES_ADDR_IRQ_STATUS)
				? reg_wdata[1:0] : 2'b00)) | {bad_pulse, done_pulse};
			flash_ready_irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_byte_q <= '0;
		end else if (reg_wr && reg_addr == FPES_ADDR_READ_DATA) begin
			rd_byte_q <= reg_wdata[31] ? data_mem[reg_wdata[DATA_AW-1:0]]
				: code_mem[reg_wdata[CODE_AW-1:0]];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				FPES_ADDR_STATUS_LOW: reg_rdata <= {24'h0, status_low_q};
				FPES_ADDR_STATUS_HIGH: reg_rdata <= {24'h0, extra_ready_q, seq_ready_q, 6'h0};
				FPES_ADDR_ENTRY: reg_rdata <= {24'h0, entry_q};
				FPES_ADDR_ADDRESS: reg_rdata <= addr_q;
				FPES_ADDR_WDATA_LO: reg_rdata <= wlo_q;
				FPES_ADDR_WDATA_HI: reg_rdata <= whi_q;
				FPES_ADDR_PROTECT: reg_rdata <= {16'h0, protect_q};
				FPES_ADDR_IRQ_STATUS: reg_rdata <= {30'h0, irq_stat_q};
				FPES_ADDR_IRQ_MASK: reg_rdata <= {30'h0, irq_mask_q};
				FPES_ADDR_CLOCK_CFG: reg_rdata <= {24'h0, clk_mhz_q};
				FPES_ADDR_READ_DATA: reg_rdata <= {24'h0, rd_byte_q};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/fpes_pkg.sv ----
`default_nettype none
package fpes_pkg;
	// register byte addresses on the plain port
	localparam logic [7:0] FPES_ADDR_STATUS_LOW  = 8'h00;
	localparam logic [7:0] FPES_ADDR_STATUS_HIGH = 8'h04;
	localparam logic [7:0] FPES_ADDR_ENTRY       = 8'h08;
	localparam logic [7:0] FPES_ADDR_COMMAND     = 8'h0C;
	localparam logic [7:0] FPES_ADDR_ADDRESS     = 8'h10;
	localparam logic [7:0] FPES_ADDR_WDATA_LO    = 8'h14;
	localparam logic [7:0] FPES_ADDR_WDATA_HI    = 8'h18;
	localparam logic [7:0] FPES_ADDR_PROTECT     = 8'h1C;
	localparam logic [7:0] FPES_ADDR_IRQ_STATUS  = 8'h20;
	localparam logic [7:0] FPES_ADDR_IRQ_MASK    = 8'h24;
	localparam logic [7:0] FPES_ADDR_CLOCK_CFG   = 8'h28;
	localparam logic [7:0] FPES_ADDR_ID_CODE     = 8'h2C;
	localparam logic [7:0] FPES_ADDR_READ_DATA   = 8'h30;

	// status bit positions
	localparam int FPES_BIT_ERASE_ERR = 0;
	localparam int FPES_BIT_PROG_ERR  = 1;
	localparam int FPES_BIT_BLANK_ERR = 3;
	localparam int FPES_BIT_EXTRA_BAD = 5;
	localparam int FPES_BIT_SEQ_READY = 6;
	localparam int FPES_BIT_EXTRA_RDY = 7;
	// entry register bits
	localparam int FPES_BIT_ENTRY_CODE = 0;
	localparam int FPES_BIT_ENTRY_DATA = 7;

	// command codes
	localparam logic [3:0] FPES_CMD_PROGRAM = 4'h1;
	localparam logic [3:0] FPES_CMD_BLANK   = 4'h2;
	localparam logic [3:0] FPES_CMD_ERASE   = 4'h3;
	localparam logic [3:0] FPES_CMD_EXTRA   = 4'h8;
	// command area select (command register bit 4)
	localparam int FPES_BIT_AREA_DATA = 4;

	// sizes
	localparam int FPES_CODE_PROG_BYTES  = 8;
	localparam int FPES_CODE_BLOCK_BYTES = 2048;
	localparam int FPES_DATA_PROG_BYTES  = 1;
	localparam int FPES_DATA_BLOCK_BYTES = 1024;
	localparam int FPES_CACHE_BYTES      = 2048;
	localparam int FPES_WAIT_LIMIT_MHZ   = 32;
	localparam logic [7:0] FPES_ERASED   = 8'hFF;

	localparam logic [7:0] FPES_RST_CLOCK_MHZ = 8'h14;
	localparam logic [31:0] FPES_RST_ZERO     = 32'h0000_0000;

	typedef enum logic [2:0] {
		FPES_IDLE,
		FPES_ERASE,
		FPES_PROG,
		FPES_BLANK,
		FPES_EXTRA,
		FPES_DONE
	} fpes_state_t;
endpackage
`default_nettype wire

// ---- testbench/fpes_asserts.sv ----
`default_nettype none
module fpes_asserts
	import fpes_pkg::*;
(
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        fetch_req,
	input wire logic        fetch_valid,
	input wire logic        boot_mode,
	input wire logic        serial_prog_enable,
	input wire logic        debug_enable,
	input wire logic        flash_ready_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic fast_q;
	logic mask_zero_q;
	// mirror of the clock and mask settings, seen only through writes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fast_q <= 1'b0;
		end else if (reg_wr && reg_addr == FPES_ADDR_CLOCK_CFG) begin
			fast_q <= reg_wdata[7:0] > 8'(FPES_WAIT_LIMIT_MHZ);
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mask_zero_q <= 1'b1;
		end else if (reg_wr && reg_addr == FPES_ADDR_IRQ_MASK) begin
			mask_zero_q <= reg_wdata == 32'h0000_0000;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence rd_at(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside read answer");
	unmapped_zero_a: assert property (rd_at(8'h3C) |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	status_bits_a: assert property (rd_at(FPES_ADDR_STATUS_LOW) |=>
		reg_rdata[31:8] == 24'h00_0000 && !reg_rdata[2] && !reg_rdata[4])
		else $error("status low reserved bits set");
	fetch_slow_a: assert property (fetch_valid && !fast_q |-> $past(fetch_req))
		else $error("wait cycle inserted at slow clock");
	fetch_cause_a: assert property (fetch_valid |-> $past(fetch_req) || $past(fetch_req, 2))
		else $error("fetch answer without request");
	serial_dbg_a: assert property (serial_prog_enable |-> debug_enable)
		else $error("serial enable without id match");
	serial_boot_a: assert property ($rose(serial_prog_enable) |-> $past(boot_mode, 3))
		else $error("serial enable outside boot mode");
	dbg_cause_a: assert property ($rose(debug_enable) |->
		$past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
		else $error("debug enable rose without id write");
	irq_masked_a: assert property (mask_zero_q && $past(mask_zero_q) |-> !flash_ready_irq)
		else $error("interrupt while fully masked");
endmodule
`default_nettype wire

// ---- testbench/fpes_cpu_model.sv ----
`default_nettype none
module fpes_cpu_model #(
	parameter int AW = 12
) (
	input  wire logic          clock,
	output var logic  [7:0]    reg_addr,
	output var logic  [31:0]   reg_wdata,
	output var logic           reg_wr,
	output var logic           reg_rd,
	input  wire logic [31:0]   reg_rdata,
	output var logic           fetch_req,
	output var logic  [AW-1:0] fetch_addr,
	input  wire logic [7:0]    fetch_data,
	input  wire logic          fetch_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		fetch_req = 1'b0;
		fetch_addr = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic fetch(input logic [AW-1:0] a, output logic [7:0] v, output int n);
		@(posedge clock);
		fetch_req <= 1'b1;
		fetch_addr <= a;
		@(posedge clock);
		fetch_req <= 1'b0;
		n = 0;
		v = 8'h00;
		for (int i = 1; i <= 3 && n == 0; i++) begin
			if (i > 1) @(posedge clock);
			#1;
			if (fetch_valid === 1'b1) begin
				n = i;
				v = fetch_data;
			end
		end
	endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s exp %h got %h", nm, (e), (g)); end end
module testbench;
	import fpes_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID = 32'h0BAD_F00D; // arbitrary value
	logic        clock, rstn, boot_mode;
	wire logic [7:0]  reg_addr, fetch_data;
	wire logic [31:0] reg_wdata, reg_rdata;
	wire logic [11:0] fetch_addr;
	wire logic        reg_wr, reg_rd, fetch_req, fetch_valid;
	wire logic        serial_prog_enable, debug_enable, flash_ready_irq;
	int          mismatches, n_tests, cycles, n;
	logic [31:0] d;
	logic [7:0]  fd;
	fpes_cpu_model #(.AW(12)) i_cpu (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .fetch_req, .fetch_addr, .fetch_data, .fetch_valid);
	fpes_top #(.CODE_BYTES(4096), .DATA_BYTES(2048), .CODE_AW(12), .DATA_AW(11),
		.STORED_ID(ID)) i_dut (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .fetch_req, .fetch_addr, .fetch_data, .fetch_valid, .boot_mode,
		.serial_prog_enable, .debug_enable, .flash_ready_irq);
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m);
		i_cpu.rd(a, d);
		`CHK(nm, e, d & m)
	endtask
	task automatic peek(logic [31:0] a, logic [7:0] e);
		i_cpu.wr(FPES_ADDR_READ_DATA, a);
		rd_chk("flash byte", FPES_ADDR_READ_DATA, {24'h00_0000, e}, 32'h0000_00FF);
	endtask
	// irq_e/irq_m: expected done/refused bits; done means accepted and busy first
	task automatic cmd(logic [31:0] a, logic [7:0] c, logic [1:0] irq_e, logic [1:0] irq_m);
		i_cpu.wr(FPES_ADDR_IRQ_STATUS, 32'h0000_0003);
		i_cpu.wr(FPES_ADDR_ADDRESS, a);
		i_cpu.wr(FPES_ADDR_COMMAND, {24'h00_0000, c});
		if (irq_e == 2'b01) rd_chk("busy", FPES_ADDR_STATUS_HIGH, 0, 32'h0000_0040);
		for (int k = 0; k < 1200; k++) begin
			i_cpu.rd(FPES_ADDR_STATUS_HIGH, d);
			if (d[6] === 1'b1) break;
		end
		`CHK("ready", 32'h0000_0040, d & 32'h0000_0040)
		rd_chk("irq status", FPES_ADDR_IRQ_STATUS, {30'h0, irq_e}, {30'h0, irq_m});
	endtask
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		rstn = 1'b0;
		boot_mode = 1'b0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		rd_chk("status low", FPES_ADDR_STATUS_LOW, 0, '1);
		rd_chk("status high", FPES_ADDR_STATUS_HIGH, 32'h0000_00C0, '1);
		rd_chk("clock cfg", FPES_ADDR_CLOCK_CFG, 32'h0000_0014, '1);
		rd_chk("unmapped", 8'h3C, 0, '1);
		$display("reset test done");
		cmd(0, {4'h0, FPES_CMD_ERASE}, 2'b10, 2'b11);
		rd_chk("erase err", FPES_ADDR_STATUS_LOW, 1, 1);
		cmd(0, 8'h11, 2'b10, 2'b11);
		rd_chk("prog err", FPES_ADDR_STATUS_LOW, 2, 2);
		cmd(0, {4'h0, FPES_CMD_EXTRA}, 2'b01, 2'b11);
		rd_chk("extra err", FPES_ADDR_STATUS_LOW, 32'h0000_0020, 32'h0000_0020);
		i_cpu.wr(FPES_ADDR_IRQ_MASK, 32'h0000_0001);
		repeat (3) @(posedge clock);
		`CHK("irq pin", 1'b1, flash_ready_irq)
		i_cpu.wr(FPES_ADDR_IRQ_STATUS, 32'h0000_0001);
		repeat (3) @(posedge clock);
		`CHK("irq cleared", 1'b0, flash_ready_irq)
		$display("refusal test done");
		i_cpu.wr(FPES_ADDR_ENTRY, 32'h0000_0080);
		fork
			cmd(0, 8'h13, 2'b01, 2'b11);
			begin
				repeat (30) @(posedge clock);
				i_cpu.fetch(12'h004, fd, n);
				`CHK("fetch in data op", 1, n)
			end
		join
		peek(32'h8000_0000, 8'hFF);
		peek(32'h8000_03FF, 8'hFF);
		i_cpu.wr(FPES_ADDR_WDATA_LO, 32'h0000_00A5);
		cmd(5, 8'h11, 2'b01, 2'b11);
		peek(32'h8000_0005, 8'hA5);
		peek(32'h8000_0006, 8'hFF);
		cmd(0, 8'h12, 2'b01, 2'b01);
		rd_chk("blank err", FPES_ADDR_STATUS_LOW, 8, 8);
		$display("data flash test done");
		i_cpu.wr(FPES_ADDR_ENTRY, 32'h0000_0001);
		i_cpu.wr(FPES_ADDR_PROTECT, 32'h0000_0000);
		cmd(32'h0000_0800, 8'h03, 2'b10, 2'b11);
		cmd(0, 8'h03, 2'b01, 2'b11);
		i_cpu.wr(FPES_ADDR_WDATA_LO, 32'h4433_2211);
		i_cpu.wr(FPES_ADDR_WDATA_HI, 32'h8877_6655);
		cmd(8, 8'h01, 2'b01, 2'b11);
		for (int k = 0; k < 8; k++) peek(8 + k, 8'(8'h11 * (k + 1)));
		peek(7, 8'hFF);
		peek(16, 8'hFF);
		peek(32'h0000_07FF, 8'hFF);
		i_cpu.wr(FPES_ADDR_ENTRY, 32'h0000_0000);
		i_cpu.fetch(12'h009, fd, n);
		`CHK("fetch slow", 8'h22, fd)
		`CHK("fetch slow wait", 1, n)
		i_cpu.wr(FPES_ADDR_CLOCK_CFG, 32'h0000_0028);
		i_cpu.fetch(12'h7FF, fd, n);
		`CHK("fetch fast", 8'hFF, fd)
		`CHK("fetch fast wait", 2, n)
		i_cpu.fetch(12'h009, fd, n);
		`CHK("fetch hit", 1, n)
		`CHK("fetch hit data", 8'h22, fd)
		$display("code flash test done");
		@(posedge clock);
		boot_mode <= 1'b1;
		i_cpu.wr(FPES_ADDR_ID_CODE, ID);
		repeat (4) @(posedge clock);
		`CHK("debug on", 1'b1, debug_enable)
		`CHK("serial on", 1'b1, serial_prog_enable)
		boot_mode <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK("serial off", 1'b0, serial_prog_enable)
		i_cpu.wr(FPES_ADDR_ID_CODE, ~ID);
		repeat (4) @(posedge clock);
		`CHK("debug off", 1'b0, debug_enable)
		$display("id test done");
		test_done();
	end
endmodule
bind fpes_top fpes_asserts i_chk (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .fetch_req, .fetch_valid, .boot_mode, .serial_prog_enable, .debug_enable,
	.flash_ready_irq);
`default_nettype wire
